// >>> rtl/adri_defines.svh
/*
  Constants of the converter result readout and interrupt block: register
  indices, field positions, widths and reset values.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef ADRI_DEFINES_SVH
`define ADRI_DEFINES_SVH

// --------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define ADRI_IDX_IRQ_FLAG_REG       10'h0E7
`define ADRI_IDX_IRQ_ENABLE_MASK    10'h0E8
`define ADRI_IDX_THRESHOLD_LOW      10'h0E9
`define ADRI_IDX_THRESHOLD_HIGH     10'h0EA
`define ADRI_IDX_CUR_INST_LOW       10'h0EB
`define ADRI_IDX_CUR_INST_HIGH      10'h0EC
`define ADRI_IDX_CUR_ACCUM_B0       10'h0ED
`define ADRI_IDX_CUR_ACCUM_B1       10'h0EE
`define ADRI_IDX_CUR_ACCUM_B2       10'h0EF
`define ADRI_IDX_CUR_ACCUM_B3       10'h0F0
`define ADRI_IDX_VOLT_INST_LOW      10'h0F1
`define ADRI_IDX_VOLT_INST_HIGH     10'h0F2
`define ADRI_IDX_VOLT_ACCUM_B0      10'h0F3
`define ADRI_IDX_VOLT_ACCUM_B1      10'h0F4
`define ADRI_IDX_VOLT_ACCUM_B2      10'h0F5
`define ADRI_IDX_VOLT_ACCUM_B3      10'h0F6
`define ADRI_IDX_CONTROL            10'h0F8
`define ADRI_IDX_READ_STATUS        10'h0F9

// --------------------------------------------------------------------------
// Interrupt flag and enable bit positions
// --------------------------------------------------------------------------
`define ADRI_BIT_VOLT_ACCUM         5
`define ADRI_BIT_VOLT_INST          4
`define ADRI_BIT_REGULAR_CURRENT    2
`define ADRI_BIT_CUR_ACCUM          1
`define ADRI_BIT_CUR_INST           0
`define ADRI_IRQ_VALID              8'h37
`define ADRI_IRQ_RESET              8'h00

// --------------------------------------------------------------------------
// Control register fields and threshold layout
// --------------------------------------------------------------------------
`define ADRI_CTRL_GLOBAL_EN         0
`define ADRI_CTRL_COUNT_LSB         4
`define ADRI_CTRL_COUNT_MSB         7
`define ADRI_THR_HIGH_MSB           6
`define ADRI_THR_RESET              15'h0000
`define ADRI_COUNT_RESET            4'h0

// --------------------------------------------------------------------------
// Result formats
// --------------------------------------------------------------------------
`define ADRI_VACC_PAD               15
`define ADRI_CACC_PAD               14
`define ADRI_INST_PAD               16
`define ADRI_RESULT_RESET           32'h0000_0000
`define ADRI_PRDATA_PAD             24

`endif

// >>> rtl/adri_pkg.sv
/*
  Types of the converter result readout and interrupt block.
  Assumes adri_defines.svh is available for inclusion.
*/
package adri_pkg;

  typedef struct packed {
    logic [31:0] data;
    logic        busy;
  } adri_lock_state_type;

  typedef struct packed {
    logic [7:0]  irq_mask;
    logic [7:0]  irq_flag;
    logic [14:0] threshold;
    logic [3:0]  rc_count_sel;
    logic        global_irq_en;
    logic [4:0]  rc_run;
    logic [7:0]  irq_req;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } adri_core_state_type;

endpackage

// >>> rtl/adri_result_lock.sv
/*
  One result register group with read-order locking: loads a new result
  unless a partial read has frozen it, and shows a busy flag meanwhile.
  Assumes read strobes are single-cycle pulses on pclk.
*/
`timescale 1ns/1ps
`include "adri_defines.svh"

module adri_result_lock
  import adri_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load_req,
  input  wire logic [31:0] load_data,
  input  wire logic        rd_low,
  input  wire logic        rd_top,
  output logic [31:0]      data_q,
  output logic             busy_q,
  output logic             loaded
);

  adri_lock_state_type st_q;
  adri_lock_state_type st_d;

  // A load in the cycle of a first low read would tear the pair
  assign loaded = load_req && !st_q.busy && !rd_low;

  always_comb begin
    st_d = st_q;
    if (loaded) begin
      st_d.data = load_data;
    end
    if (rd_low) begin
      st_d.busy = 1'b1;
    end else if (rd_top) begin
      st_d.busy = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.data <= `ADRI_RESULT_RESET;
      st_q.busy <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign data_q = st_q.data;
  assign busy_q = st_q.busy;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lock_freeze: assert property (rd_low |=> busy_q)
    else $error("busy not raised after low read");
  a_lock_hold: assert property (busy_q && !rd_top |=> $stable(data_q))
    else $error("frozen result changed");
  a_lock_release: assert property (rd_top && !rd_low |=> !busy_q)
    else $error("busy not released after top read");

endmodule

// >>> rtl/adri_readout.sv
/*
  Result readout and interrupt logic of the voltage and current converters,
  reached over APB: interrupt flags and mask, regular-current threshold and
  detection, and four locked result groups.
  Assumes converter results and done pulses arrive on pclk, done is a
  one-cycle pulse with its data valid in that cycle.
*/
`timescale 1ns/1ps
`include "adri_defines.svh"

module adri_readout
  import adri_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        volt_inst_done,
  input  wire logic [15:0] volt_inst_data,
  input  wire logic        volt_accum_done,
  input  wire logic [16:0] volt_accum_data,
  input  wire logic        cur_inst_done,
  input  wire logic [15:0] cur_inst_data,
  input  wire logic        cur_accum_done,
  input  wire logic [17:0] cur_accum_data,
  input  wire logic [7:0]  irq_ack,
  output logic [7:0]       irq_req,
  output logic             volt_inst_read_busy,
  output logic             volt_accum_read_busy,
  output logic             cur_inst_read_busy,
  output logic             cur_accum_read_busy
);

  // --------------------------------------------------------------------------
  // Address decoding
  // --------------------------------------------------------------------------
  function automatic logic [9:0] adri_index(input logic [11:0] addr);
    return addr[11:2];
  endfunction

  function automatic logic adri_mapped(input logic [11:0] addr);
    logic [9:0] idx;
    idx = adri_index(addr);
    return (addr[1:0] == 2'b00) &&
           (((idx >= `ADRI_IDX_IRQ_FLAG_REG) && (idx <= `ADRI_IDX_VOLT_ACCUM_B3)) ||
            (idx == `ADRI_IDX_CONTROL) || (idx == `ADRI_IDX_READ_STATUS));
  endfunction

  function automatic logic adri_hit(input logic [11:0] addr, input logic [9:0] idx);
    return (addr[1:0] == 2'b00) && (adri_index(addr) == idx);
  endfunction

  adri_core_state_type st_q;
  adri_core_state_type st_d;

  logic        apb_setup;
  logic        apb_rd_setup;
  logic        apb_write;
  logic [9:0]  idx;
  logic [7:0]  rd_byte;
  logic [7:0]  set_vec;
  logic [7:0]  clr_vec;
  logic [4:0]  rc_target;
  logic        rc_exceed;
  logic        rc_fire;
  logic        flag_wr;

  logic [31:0] vinst_q;
  logic [31:0] vacc_q;
  logic [31:0] cinst_q;
  logic [31:0] cacc_q;
  logic        vinst_loaded;
  logic        vacc_loaded;
  logic        cinst_loaded;
  logic        cacc_loaded;

  assign idx          = adri_index(paddr);
  assign apb_setup    = psel && !penable;
  assign apb_rd_setup = apb_setup && !pwrite;
  // Writes land at the completing access edge
  assign apb_write    = psel && penable && pwrite && st_q.pready;
  assign flag_wr      = apb_write && adri_hit(paddr, `ADRI_IDX_IRQ_FLAG_REG);

  // --------------------------------------------------------------------------
  // Result groups
  // --------------------------------------------------------------------------
  adri_result_lock u_volt_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .load_req  (volt_inst_done),
    .load_data ({{`ADRI_INST_PAD{1'b0}}, volt_inst_data}),
    .rd_low    (apb_rd_setup && adri_hit(paddr, `ADRI_IDX_VOLT_INST_LOW)),
    .rd_top    (apb_rd_setup && adri_hit(paddr, `ADRI_IDX_VOLT_INST_HIGH)),
    .data_q    (vinst_q),
    .busy_q    (volt_inst_read_busy),
    .loaded    (vinst_loaded)
  );

  adri_result_lock u_volt_accum (
    .pclk      (pclk),
    .presetn   (presetn),
    .load_req  (volt_accum_done),
    .load_data ({volt_accum_data, {`ADRI_VACC_PAD{1'b0}}}),
    .rd_low    (apb_rd_setup && (adri_hit(paddr, `ADRI_IDX_VOLT_ACCUM_B0) ||
                adri_hit(paddr, `ADRI_IDX_VOLT_ACCUM_B1) ||
                adri_hit(paddr, `ADRI_IDX_VOLT_ACCUM_B2))),
    .rd_top    (apb_rd_setup && adri_hit(paddr, `ADRI_IDX_VOLT_ACCUM_B3)),
    .data_q    (vacc_q),
    .busy_q    (volt_accum_read_busy),
    .loaded    (vacc_loaded)
  );

  adri_result_lock u_cur_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .load_req  (cur_inst_done),
    .load_data ({{`ADRI_INST_PAD{1'b0}}, cur_inst_data}),
    .rd_low    (apb_rd_setup && adri_hit(paddr, `ADRI_IDX_CUR_INST_LOW)),
    .rd_top    (apb_rd_setup && adri_hit(paddr, `ADRI_IDX_CUR_INST_HIGH)),
    .data_q    (cinst_q),
    .busy_q    (cur_inst_read_busy),
    .loaded    (cinst_loaded)
  );

  adri_result_lock u_cur_accum (
    .pclk      (pclk),
    .presetn   (presetn),
    .load_req  (cur_accum_done),
    .load_data ({cur_accum_data, {`ADRI_CACC_PAD{cur_accum_data[17]}}}),
    .rd_low    (apb_rd_setup && (adri_hit(paddr, `ADRI_IDX_CUR_ACCUM_B0) ||
                adri_hit(paddr, `ADRI_IDX_CUR_ACCUM_B1) ||
                adri_hit(paddr, `ADRI_IDX_CUR_ACCUM_B2))),
    .rd_top    (apb_rd_setup && adri_hit(paddr, `ADRI_IDX_CUR_ACCUM_B3)),
    .data_q    (cacc_q),
    .busy_q    (cur_accum_read_busy),
    .loaded    (cacc_loaded)
  );

  // --------------------------------------------------------------------------
  // Regular-current detection
  // --------------------------------------------------------------------------
  assign rc_target = {1'b0, st_q.rc_count_sel} + 5'h01;
  assign rc_exceed = $signed(cur_accum_data) > $signed({3'b000, st_q.threshold});
  assign rc_fire   = cur_accum_done && rc_exceed && ((st_q.rc_run + 5'h01) == rc_target);

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `ADRI_IDX_IRQ_FLAG_REG:    rd_byte = st_q.irq_flag & `ADRI_IRQ_VALID;
      `ADRI_IDX_IRQ_ENABLE_MASK: rd_byte = st_q.irq_mask & `ADRI_IRQ_VALID;
      `ADRI_IDX_THRESHOLD_LOW:   rd_byte = st_q.threshold[7:0];
      `ADRI_IDX_THRESHOLD_HIGH:  rd_byte = {1'b0, st_q.threshold[14:8]};
      `ADRI_IDX_CUR_INST_LOW:    rd_byte = cinst_q[7:0];
      `ADRI_IDX_CUR_INST_HIGH:   rd_byte = cinst_q[15:8];
      `ADRI_IDX_CUR_ACCUM_B0:    rd_byte = cacc_q[7:0];
      `ADRI_IDX_CUR_ACCUM_B1:    rd_byte = cacc_q[15:8];
      `ADRI_IDX_CUR_ACCUM_B2:    rd_byte = cacc_q[23:16];
      `ADRI_IDX_CUR_ACCUM_B3:    rd_byte = cacc_q[31:24];
      `ADRI_IDX_VOLT_INST_LOW:   rd_byte = vinst_q[7:0];
      `ADRI_IDX_VOLT_INST_HIGH:  rd_byte = vinst_q[15:8];
      `ADRI_IDX_VOLT_ACCUM_B0:   rd_byte = vacc_q[7:0];
      `ADRI_IDX_VOLT_ACCUM_B1:   rd_byte = vacc_q[15:8];
      `ADRI_IDX_VOLT_ACCUM_B2:   rd_byte = vacc_q[23:16];
      `ADRI_IDX_VOLT_ACCUM_B3:   rd_byte = vacc_q[31:24];
      `ADRI_IDX_CONTROL:         rd_byte = {st_q.rc_count_sel, 3'b000, st_q.global_irq_en};
      `ADRI_IDX_READ_STATUS:     rd_byte = {4'h0, volt_accum_read_busy, volt_inst_read_busy,
                                            cur_accum_read_busy, cur_inst_read_busy};
      default:                   rd_byte = 8'h00;
    endcase
    if (paddr[1:0] != 2'b00) begin
      rd_byte = 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    set_vec = 8'h00;
    clr_vec = irq_ack;
    st_d = st_q;
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    if (apb_setup) begin
      st_d.pready  = 1'b1;
      st_d.pslverr = !adri_mapped(paddr);
      st_d.prdata  = pwrite ? st_q.prdata : {{`ADRI_PRDATA_PAD{1'b0}}, rd_byte};
    end
    if (apb_write) begin
      if (adri_hit(paddr, `ADRI_IDX_IRQ_ENABLE_MASK)) begin
        st_d.irq_mask = pwdata[7:0] & `ADRI_IRQ_VALID;
      end
      if (adri_hit(paddr, `ADRI_IDX_THRESHOLD_LOW)) begin
        st_d.threshold[7:0] = pwdata[7:0];
      end
      if (adri_hit(paddr, `ADRI_IDX_THRESHOLD_HIGH)) begin
        st_d.threshold[14:8] = pwdata[`ADRI_THR_HIGH_MSB:0];
      end
      if (adri_hit(paddr, `ADRI_IDX_CONTROL)) begin
        st_d.global_irq_en = pwdata[`ADRI_CTRL_GLOBAL_EN];
        st_d.rc_count_sel  = pwdata[`ADRI_CTRL_COUNT_MSB:`ADRI_CTRL_COUNT_LSB];
      end
    end
    if (flag_wr) begin
      clr_vec = clr_vec | pwdata[7:0];
    end
    // Consecutive exceedance counter
    if (cur_accum_done) begin
      if (!rc_exceed) begin
        st_d.rc_run = 5'h00;
      end else if (rc_fire) begin
        st_d.rc_run = 5'h00;
      end else begin
        st_d.rc_run = st_q.rc_run + 5'h01;
      end
    end
    set_vec[`ADRI_BIT_CUR_INST]         = cinst_loaded;
    set_vec[`ADRI_BIT_CUR_ACCUM]        = cacc_loaded;
    set_vec[`ADRI_BIT_VOLT_INST]        = vinst_loaded;
    set_vec[`ADRI_BIT_VOLT_ACCUM]       = vacc_loaded;
    set_vec[`ADRI_BIT_REGULAR_CURRENT]  = rc_fire;
    // Set wins over a clear in the same cycle
    st_d.irq_flag = ((st_q.irq_flag & ~clr_vec) | set_vec) & `ADRI_IRQ_VALID;
    st_d.irq_req  = st_q.irq_flag & st_q.irq_mask &
                    {8{st_q.global_irq_en}};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.irq_mask      <= `ADRI_IRQ_RESET;
      st_q.irq_flag      <= `ADRI_IRQ_RESET;
      st_q.threshold     <= `ADRI_THR_RESET;
      st_q.rc_count_sel  <= `ADRI_COUNT_RESET;
      st_q.global_irq_en <= 1'b0;
      st_q.rc_run        <= 5'h00;
      st_q.irq_req       <= `ADRI_IRQ_RESET;
      st_q.prdata        <= `ADRI_RESULT_RESET;
      st_q.pready        <= 1'b0;
      st_q.pslverr       <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.prdata;
  assign pready  = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign irq_req = st_q.irq_req;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("APB answer not one cycle after setup");
  a_cinst_flag: assert property (cinst_loaded |=> st_q.irq_flag[0])
    else $error("current instantaneous flag not set");
  a_irq_gate: assert property (st_q.irq_flag[0] && st_q.irq_mask[0] &&
      st_q.global_irq_en |=> irq_req[0])
    else $error("enabled request not raised");
  a_irq_block: assert property (!st_q.global_irq_en |=> irq_req == 8'h00)
    else $error("request raised with global enable off");
  a_flag_w1c: assert property (flag_wr && pwdata[0] && !cinst_loaded |=>
      !st_q.irq_flag[0])
    else $error("write one did not clear flag");
  a_flag_ack: assert property (irq_ack[1] && !cacc_loaded |=> !st_q.irq_flag[1])
    else $error("vector entry did not clear flag");
  a_mask_write: assert property (
      apb_write && adri_hit(paddr, `ADRI_IDX_IRQ_ENABLE_MASK) |=>
      st_q.irq_mask == ($past(pwdata[7:0]) & `ADRI_IRQ_VALID))
    else $error("mask write wrong");
  a_mask_read: assert property (
      apb_rd_setup && adri_hit(paddr, `ADRI_IDX_IRQ_ENABLE_MASK) |=>
      prdata[7:6] == 2'b00 && !prdata[3])
    else $error("reserved mask bits read as one");
  a_thr_low: assert property (apb_write && adri_hit(paddr, `ADRI_IDX_THRESHOLD_LOW)
      |=> st_q.threshold[7:0] == $past(pwdata[7:0]))
    else $error("threshold low write wrong");
  a_thr_read: assert property (
      apb_rd_setup && adri_hit(paddr, `ADRI_IDX_THRESHOLD_HIGH) |=>
      !prdata[7])
    else $error("threshold top bit read as one");
  a_vinst_flag: assert property (vinst_loaded |=> st_q.irq_flag[`ADRI_BIT_VOLT_INST])
    else $error("voltage instantaneous flag not set");
  a_vacc_flag: assert property (vacc_loaded |=> st_q.irq_flag[`ADRI_BIT_VOLT_ACCUM])
    else $error("voltage accumulated flag not set");
  a_cacc_flag: assert property (cacc_loaded |=> st_q.irq_flag[`ADRI_BIT_CUR_ACCUM])
    else $error("current accumulated flag not set");
  a_thr_high: assert property (apb_write && adri_hit(paddr, `ADRI_IDX_THRESHOLD_HIGH)
      |=> st_q.threshold[14:8] == $past(pwdata[6:0]))
    else $error("threshold high write wrong");
  a_rc_detect: assert property (rc_fire |=> st_q.irq_flag[2] && st_q.rc_run == 5'h00)
    else $error("regular current flag not set");
  a_rc_bound: assert property (st_q.rc_run <= {1'b0, st_q.rc_count_sel})
    else $error("exceedance count overran");
  a_vacc_pad: assert property (vacc_q[14:0] == 15'h0000)
    else $error("voltage accumulated low bits not zero");
  a_cacc_pad: assert property (cacc_q[13:0] == {14{cacc_q[31]}})
    else $error("current accumulated pad not sign");

endmodule

// >>> bench/adri_conv_model.sv
/*
  Behavioural model of the voltage and current converter front ends: each
  conversion is a one-cycle done pulse with its result beside it.
  Assumes one conversion at a time, started by the bench through conv.
*/
`timescale 1ns/1ps

module adri_conv_model (
  input  wire logic        pclk,
  output logic             volt_inst_done,
  output logic [15:0]      volt_inst_data,
  output logic             volt_accum_done,
  output logic [16:0]      volt_accum_data,
  output logic             cur_inst_done,
  output logic [15:0]      cur_inst_data,
  output logic             cur_accum_done,
  output logic [17:0]      cur_accum_data
);
  initial begin
    {volt_inst_done, volt_accum_done, cur_inst_done, cur_accum_done} = 4'h0;
    {volt_inst_data, volt_accum_data, cur_inst_data, cur_accum_data} = 67'h0;
  end

  // --------------------------------------------------------------------------
  // Conversion pulse; channel numbers follow the flag bit positions
  // --------------------------------------------------------------------------
  task automatic conv(input int ch, input logic [17:0] d);
    @(posedge pclk);
    cur_inst_done   <= (ch == 0);
    cur_accum_done  <= (ch == 1);
    volt_inst_done  <= (ch == 4);
    volt_accum_done <= (ch == 5);
    cur_inst_data   <= (ch == 0) ? d[15:0] : ~cur_inst_data;
    cur_accum_data  <= (ch == 1) ? d : ~cur_accum_data;
    volt_inst_data  <= (ch == 4) ? d[15:0] : ~volt_inst_data;
    volt_accum_data <= (ch == 5) ? d[16:0] : ~volt_accum_data;
    @(posedge pclk);
    {volt_inst_done, volt_accum_done, cur_inst_done, cur_accum_done} <= 4'h0;
    // Results are only valid with the pulse, so they do not linger
    {volt_inst_data, volt_accum_data} <= ~{volt_inst_data, volt_accum_data};
    {cur_inst_data, cur_accum_data} <= ~{cur_inst_data, cur_accum_data};
  endtask
endmodule

// >>> bench/testbench.sv
/*
  Self-checking bench of the converter readout block over APB.
  Assumes adri_defines.svh and adri_pkg are compiled with the design.
*/
`timescale 1ns/1ps
`include "adri_defines.svh"

module testbench;
  import adri_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  irq_ack, irq_req;
  logic        volt_inst_done, volt_accum_done, cur_inst_done, cur_accum_done;
  logic [15:0] volt_inst_data, cur_inst_data;
  logic [16:0] volt_accum_data;
  logic [17:0] cur_accum_data;
  logic        volt_inst_read_busy, volt_accum_read_busy;
  logic        cur_inst_read_busy, cur_accum_read_busy;
  logic [3:0]  busy;
  int          failures, compares;
  int          chs[4] = '{0, 1, 4, 5};

  assign busy = {volt_accum_read_busy, volt_inst_read_busy, cur_accum_read_busy,
                 cur_inst_read_busy};

  adri_readout adri_readout_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .volt_inst_done, .volt_inst_data,
    .volt_accum_done, .volt_accum_data, .cur_inst_done, .cur_inst_data,
    .cur_accum_done, .cur_accum_data, .irq_ack, .irq_req, .volt_inst_read_busy,
    .volt_accum_read_busy, .cur_inst_read_busy, .cur_accum_read_busy);

  adri_conv_model adri_conv_model_i (.pclk, .volt_inst_done, .volt_inst_data,
    .volt_accum_done, .volt_accum_data, .cur_inst_done, .cur_inst_data,
    .cur_accum_done, .cur_accum_data);

  always #5 pclk = ~pclk;

  // --------------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic ack(input int b);
    @(posedge pclk);
    irq_ack <= 8'h01 << b;
    @(posedge pclk);
    irq_ack <= 8'h00;
  endtask

  // Low bytes first, one dropped load while frozen, then the top byte
  task automatic grp(input string nm, input logic [9:0] base, input int n, input int ch,
                     input int bb, input logic [17:0] raw, input logic [31:0] exp);
    adri_conv_model_i.conv(ch, raw);
    for (int i = 0; i < n; i++) begin
      rdchk(nm, base + 10'(i), 32'(exp[8*i +: 8]));
      chk("read busy", 32'(busy[bb]), 32'(i < n - 1));
      rdchk("read status", `ADRI_IDX_READ_STATUS, 32'(i < n - 1) << bb);
      if (i == 0)
        adri_conv_model_i.conv(ch, ~raw);
    end
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, irq_ack} = 0;
    failures = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 'h0E7; i <= 'h0F6; i++)
      rdchk("reset value", 10'(i), 32'h0);
    apb(1'b0, 10'h000, 8'h00);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, `ADRI_IDX_IRQ_ENABLE_MASK, 8'hFF);
    rdchk("enable mask", `ADRI_IDX_IRQ_ENABLE_MASK, 32'h37);
    apb(1'b1, `ADRI_IDX_THRESHOLD_HIGH, 8'hFF);
    rdchk("threshold high", `ADRI_IDX_THRESHOLD_HIGH, 32'h7F);
    apb(1'b1, `ADRI_IDX_THRESHOLD_LOW, 8'hA5);
    rdchk("threshold low", `ADRI_IDX_THRESHOLD_LOW, 32'hA5);
    $display("Test registers done");

    grp("volt inst", `ADRI_IDX_VOLT_INST_LOW, 2, 4, 2, 18'h0A5C3, 32'hA5C3);
    grp("volt inst", `ADRI_IDX_VOLT_INST_LOW, 2, 4, 2, 18'h05A3C, 32'h5A3C);
    grp("volt acc", `ADRI_IDX_VOLT_ACCUM_B0, 4, 5, 3, 18'h1ABCD, {17'h1ABCD, 15'h0});
    grp("cur inst", `ADRI_IDX_CUR_INST_LOW, 2, 0, 0, 18'h08001, 32'h8001);
    grp("cur acc", `ADRI_IDX_CUR_ACCUM_B0, 4, 1, 1, 18'h20001, {18'h20001, 14'h3FFF});
    grp("cur acc", `ADRI_IDX_CUR_ACCUM_B0, 4, 1, 1, 18'h1FFFF, {18'h1FFFF, 14'h0});
    $display("Test result groups done");

    apb(1'b1, `ADRI_IDX_IRQ_FLAG_REG, 8'h37);
    rdchk("flags cleared", `ADRI_IDX_IRQ_FLAG_REG, 32'h0);
    foreach (chs[k]) begin
      apb(1'b1, `ADRI_IDX_CONTROL, 8'h01);
      apb(1'b1, `ADRI_IDX_IRQ_ENABLE_MASK, 8'h00);
      adri_conv_model_i.conv(chs[k], 18'h00001);
      settle();
      chk("masked request", {24'h0, irq_req}, 32'h0);
      apb(1'b1, `ADRI_IDX_IRQ_FLAG_REG, 8'h00);
      rdchk("flag set", `ADRI_IDX_IRQ_FLAG_REG, 32'h1 << chs[k]);
      apb(1'b1, `ADRI_IDX_IRQ_ENABLE_MASK, 8'h01 << chs[k]);
      settle();
      chk("request", {24'h0, irq_req}, 32'h1 << chs[k]);
      apb(1'b1, `ADRI_IDX_CONTROL, 8'h00);
      settle();
      chk("global off", {24'h0, irq_req}, 32'h0);
      if (k[0])
        ack(chs[k]);
      else
        apb(1'b1, `ADRI_IDX_IRQ_FLAG_REG, 8'h01 << chs[k]);
      rdchk("flag clear", `ADRI_IDX_IRQ_FLAG_REG, 32'h0);
    end
    $display("Test interrupts done");

    apb(1'b1, `ADRI_IDX_THRESHOLD_HIGH, 8'h00);
    apb(1'b1, `ADRI_IDX_THRESHOLD_LOW, 8'h10);
    apb(1'b1, `ADRI_IDX_CONTROL, 8'h31);
    rdchk("control", `ADRI_IDX_CONTROL, 32'h31);
    apb(1'b1, `ADRI_IDX_IRQ_ENABLE_MASK, 8'h04);
    for (int i = 0; i < 8; i++) begin
      adri_conv_model_i.conv(1, (i == 3) ? 18'h00010 : 18'h00011);
      rdchk("regular current", `ADRI_IDX_IRQ_FLAG_REG, (i == 7) ? 32'h06 : 32'h02);
    end
    settle();
    chk("regular request", {24'h0, irq_req}, 32'h04);
    ack(2);
    rdchk("regular cleared", `ADRI_IDX_IRQ_FLAG_REG, 32'h02);
    $display("Test regular current done");
    end_sim();
  end
endmodule
